// ---- dcrt_cfg.svh ----
// dcrt_cfg.svh: offsets, field positions, reset values and timing counts of the channel block
`ifndef DCRT_CFG_SVH
`define DCRT_CFG_SVH

// =============================================================
// cpu i/o offsets (byte-wide port)
`define DCRT_OFF_CMD 4'h8
`define DCRT_OFF_MODE 4'hb
`define DCRT_OFF_CLR_FF 4'hc
`define DCRT_OFF_MCLR 4'hd
`define DCRT_OFF_CLR_MODE 4'he

// =============================================================
// subsystem_control bit positions
`define DCRT_CMD_MM 0
`define DCRT_CMD_AH 1
`define DCRT_CMD_CD 2
`define DCRT_CMD_CT 3
`define DCRT_CMD_RP 4
`define DCRT_CMD_EW 5
`define DCRT_CMD_REQP 6
`define DCRT_CMD_ACKP 7

// =============================================================
// stored mode bits (mode byte bits 7..2 kept as 5..0)
`define DCRT_MODE_DEC 3
`define DCRT_MODE_AI 2

// =============================================================
// reset values and constants
`define DCRT_CMD_RST 8'h00
`define DCRT_MODE_RST 6'h00
`define DCRT_WORD_RST 16'h0000
`define DCRT_MODE_RD_LOW 2'h3
`define DCRT_CNT_ZERO 16'h0000
`define DCRT_STEP 16'h0001

// =============================================================
// extra wait states after the first one
`define DCRT_WAITS_NORMAL 2'h1
`define DCRT_WAITS_SHORT 2'h0

`endif

// ---- dcrt_pkg.sv ----
// dcrt_pkg.sv: types shared by the channel block
package dcrt_pkg;
    typedef enum logic [2:0] {ST_IDLE, ST_LATCH, ST_CMD, ST_WAIT, ST_FIN} dcrt_state_t;
    typedef enum logic [1:0] {SVC_DEMAND, SVC_SINGLE, SVC_BLOCK, SVC_CASCADE} dcrt_svc_t;
    typedef enum logic [1:0] {TT_VERIFY, TT_WRITE, TT_READ, TT_ILLEGAL} dcrt_xtype_t;
endpackage

// ---- dcrt_core.sv ----
// dcrt_core.sv: four-channel register set and transfer timing engine
`timescale 1ns/100ps
`include "dcrt_cfg.svh"

module dcrt_core #(
    parameter int XW = 19,
    parameter int XDEPTH = 2
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic [3:0] channel_request,
    output logic [3:0] channel_acknowledge,
    input wire logic io_ready,
    output logic [15:0] addr_out,
    output logic addr_strobe,
    output logic terminal_count,
    output logic mem_rd_cmd,
    output logic mem_wr_cmd,
    output logic io_rd_cmd,
    output logic io_wr_cmd,
    output logic [3:0] mask_set,
    output logic xfer_valid,
    input wire logic xfer_ready,
    output logic [XW-1:0] xfer_data
);
    localparam int AW = (XDEPTH > 1) ? $clog2(XDEPTH) : 1;
    localparam int CW = $clog2(XDEPTH + 1);

    // =============================================================
    // state
    logic [7:0] cmd_q;
    logic [15:0] addr_q [4];
    logic [15:0] cnt_q [4];
    logic [15:0] base_addr_q [4];
    logic [15:0] base_cnt_q [4];
    logic [5:0] mode_q [4];
    logic [15:0] addr_nx [4];
    logic [3:0] halted_q, mask_set_q, cascade, ack_hit;
    logic ff_q, mm_wr_q, mm_wr_d, hi_valid_q;
    logic [1:0] mrd_q, chan_q, chan_d, last_q, wait_q, wait_d, gnt;
    logic [7:0] hi_last_q, rdata_q;
    logic found;
    dcrt_pkg::dcrt_state_t state_q, state_d;
    logic [XW-1:0] fifo_q [XDEPTH];
    logic [AW-1:0] wp_q, rp_q;
    logic [CW-1:0] fcnt_q;

    // =============================================================
    // cpu decode
    wire ch_acc = !io_addr[3];
    wire [1:0] acc_ch = io_addr[2:1];
    wire acc_cnt = io_addr[0];
    wire wr_cmd = io_wr && io_addr == `DCRT_OFF_CMD;
    wire wr_mode = io_wr && io_addr == `DCRT_OFF_MODE;
    wire rd_mode = io_rd && io_addr == `DCRT_OFF_MODE;
    wire mclr = io_wr && io_addr == `DCRT_OFF_MCLR;
    wire clr_ff = io_wr && io_addr == `DCRT_OFF_CLR_FF;
    wire clr_mode = io_wr && io_addr == `DCRT_OFF_CLR_MODE;

    // control fields
    wire mm_en = cmd_q[`DCRT_CMD_MM];
    wire src_hold = cmd_q[`DCRT_CMD_AH];
    wire sub_off = cmd_q[`DCRT_CMD_CD];
    wire short_tm = cmd_q[`DCRT_CMD_CT];
    wire rot = cmd_q[`DCRT_CMD_RP];
    wire early_wr = cmd_q[`DCRT_CMD_EW];
    wire req_pol = cmd_q[`DCRT_CMD_REQP];
    wire ack_pol = cmd_q[`DCRT_CMD_ACKP];

    // read mux; the mode read shows the stored six bits over two ones
    wire [15:0] rd_word = acc_cnt ? cnt_q[acc_ch] : addr_q[acc_ch];
    wire [7:0] rd_mux = ch_acc ? (ff_q ? rd_word[15:8] : rd_word[7:0]) :
        (io_addr == `DCRT_OFF_CMD) ? cmd_q :
        (io_addr == `DCRT_OFF_MODE) ? {mode_q[mrd_q], `DCRT_MODE_RD_LOW} : 8'h00;

    // =============================================================
    // active channel view; in the paired mode the write phase uses channel 1
    wire mm_act = mm_en && chan_q == 2'h0;
    wire [1:0] act_chan = mm_wr_q ? 2'h1 : chan_q;
    wire [15:0] cur_addr = addr_q[act_chan];
    wire tc_now = cnt_q[act_chan] == `DCRT_CNT_ZERO;
    wire tc_end = tc_now && (!mm_act || mm_wr_q);
    wire [5:0] cur_mode = mode_q[chan_q];
    wire [1:0] svc = cur_mode[5:4];
    wire [1:0] xt = cur_mode[1:0];
    wire no_cmd = !mm_act && (xt == dcrt_pkg::TT_VERIFY || xt == dcrt_pkg::TT_ILLEGAL);
    wire fin = state_q == dcrt_pkg::ST_FIN;
    wire room = fcnt_q != CW'(XDEPTH);
    wire [3:0] req_act = (channel_request ^ {4{req_pol}}) & ~halted_q & ~cascade;
    // a verify cycle never waits on ready since nothing moves on the bus
    wire wait_done = wait_q == 2'h0 && (io_ready || no_cmd);
    wire room_next = fcnt_q < CW'(XDEPTH - 1) || (xfer_valid && xfer_ready); // this push uses a slot
    wire keep_going = !tc_end && !sub_off && room_next &&
        (mm_act || svc == dcrt_pkg::SVC_BLOCK ||
        (svc == dcrt_pkg::SVC_DEMAND && req_act[chan_q]));
    wire [1:0] nxt_act = (mm_act && !mm_wr_q) ? 2'h1 : chan_q;
    // refresh the external latch only when the upper byte is about to change
    wire need_latch = !hi_valid_q || addr_nx[nxt_act][15:8] != hi_last_q;

    // =============================================================
    // per-channel registers
    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : g_ch
            wire upd = fin && act_chan == 2'(c);
            wire tcx = upd && cnt_q[c] == `DCRT_CNT_ZERO;
            wire ai = mode_q[c][`DCRT_MODE_AI];
            wire dec = mode_q[c][`DCRT_MODE_DEC];
            wire hold = (c == 0) && mm_en && src_hold;
            wire wa = io_wr && ch_acc && acc_ch == 2'(c) && !acc_cnt;
            wire wc = io_wr && ch_acc && acc_ch == 2'(c) && acc_cnt;
            wire [15:0] step = dec ? addr_q[c] - `DCRT_STEP : addr_q[c] + `DCRT_STEP;
            wire [15:0] cnt_nx = (tcx && ai) ? base_cnt_q[c] :
                upd ? cnt_q[c] - `DCRT_STEP : cnt_q[c];
            assign cascade[c] = mode_q[c][5:4] == dcrt_pkg::SVC_CASCADE;
            assign ack_hit[c] = state_q != dcrt_pkg::ST_IDLE && chan_q == 2'(c);
            assign addr_nx[c] = (tcx && ai) ? base_addr_q[c] :
                (upd && !hold) ? step : addr_q[c];

            // cpu byte writes land in current and base copies together
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    addr_q[c] <= `DCRT_WORD_RST;
                    base_addr_q[c] <= `DCRT_WORD_RST;
                end else if (wa && ff_q) begin
                    addr_q[c][15:8] <= io_wdata;
                    base_addr_q[c][15:8] <= io_wdata;
                end else if (wa) begin
                    addr_q[c][7:0] <= io_wdata;
                    base_addr_q[c][7:0] <= io_wdata;
                end else begin
                    addr_q[c] <= addr_nx[c];
                end
            end

            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    cnt_q[c] <= `DCRT_WORD_RST;
                    base_cnt_q[c] <= `DCRT_WORD_RST;
                end else if (wc && ff_q) begin
                    cnt_q[c][15:8] <= io_wdata;
                    base_cnt_q[c][15:8] <= io_wdata;
                end else if (wc) begin
                    cnt_q[c][7:0] <= io_wdata;
                    base_cnt_q[c][7:0] <= io_wdata;
                end else begin
                    cnt_q[c] <= cnt_nx;
                end
            end

            // halt at rollover wins over a same-cycle clear
            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    halted_q[c] <= 1'b0;
                    mask_set_q[c] <= 1'b0;
                    mode_q[c] <= `DCRT_MODE_RST;
                end else begin
                    halted_q[c] <= (tcx && !ai) || (halted_q[c] && !(mclr || wc));
                    mask_set_q[c] <= tcx && !ai;
                    if (wr_mode && io_wdata[1:0] == 2'(c))
                        mode_q[c] <= io_wdata[7:2];
                end
            end
        end
    endgenerate

    // =============================================================
    // control register, byte pointer and mode read counter
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cmd_q <= `DCRT_CMD_RST;
            ff_q <= 1'b0;
            mrd_q <= 2'h0;
            rdata_q <= 8'h00;
        end else begin
            if (mclr)
                cmd_q <= `DCRT_CMD_RST;
            else if (wr_cmd)
                cmd_q <= io_wdata;
            if (mclr || clr_ff)
                ff_q <= 1'b0;
            else if ((io_wr || io_rd) && ch_acc)
                ff_q <= !ff_q;
            if (mclr || clr_mode)
                mrd_q <= 2'h0;
            else if (rd_mode)
                mrd_q <= mrd_q + 2'h1;
            if (io_rd)
                rdata_q <= rd_mux;
        end
    end

    // =============================================================
    // priority: fixed from channel 0, or rotating after the last served
    always_comb begin
        logic [1:0] idx;
        idx = 2'h0;
        found = 1'b0;
        gnt = 2'h0;
        for (int i = 0; i < 4; i++) begin
            idx = rot ? 2'(last_q + 2'(i + 1)) : 2'(i);
            if (!found && req_act[idx]) begin
                found = 1'b1;
                gnt = idx;
            end
        end
    end

    // =============================================================
    // cycle sequencer; the grant is frozen until the service ends
    always_comb begin
        state_d = state_q;
        chan_d = chan_q;
        mm_wr_d = mm_wr_q;
        wait_d = wait_q;
        case (state_q)
            dcrt_pkg::ST_IDLE: begin
                if (found && !sub_off && room) begin
                    chan_d = gnt;
                    mm_wr_d = 1'b0;
                    state_d = dcrt_pkg::ST_LATCH;
                end
            end
            dcrt_pkg::ST_LATCH: state_d = dcrt_pkg::ST_CMD;
            dcrt_pkg::ST_CMD: begin
                state_d = dcrt_pkg::ST_WAIT;
                wait_d = short_tm ? `DCRT_WAITS_SHORT : `DCRT_WAITS_NORMAL;
            end
            dcrt_pkg::ST_WAIT: begin
                if (wait_q != 2'h0)
                    wait_d = wait_q - 2'h1;
                else if (wait_done)
                    state_d = dcrt_pkg::ST_FIN;
            end
            dcrt_pkg::ST_FIN: begin
                if (mm_act && !mm_wr_q) begin
                    mm_wr_d = 1'b1;
                    state_d = need_latch ? dcrt_pkg::ST_LATCH : dcrt_pkg::ST_CMD;
                end else if (keep_going) begin
                    mm_wr_d = 1'b0;
                    state_d = need_latch ? dcrt_pkg::ST_LATCH : dcrt_pkg::ST_CMD;
                end else begin
                    state_d = dcrt_pkg::ST_IDLE;
                end
            end
            default: state_d = dcrt_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_q <= dcrt_pkg::ST_IDLE;
            chan_q <= 2'h0;
            last_q <= 2'h3;
            mm_wr_q <= 1'b0;
            wait_q <= 2'h0;
        end else begin
            state_q <= state_d;
            chan_q <= chan_d;
            mm_wr_q <= mm_wr_d;
            wait_q <= wait_d;
            if (state_q == dcrt_pkg::ST_IDLE && state_d != dcrt_pkg::ST_IDLE)
                last_q <= gnt;
        end
    end

    // latch tracking; forgotten between services so each starts with a refresh
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            hi_valid_q <= 1'b0;
            hi_last_q <= 8'h00;
        end else if (state_q == dcrt_pkg::ST_IDLE) begin
            hi_valid_q <= 1'b0;
        end else if (state_q == dcrt_pkg::ST_LATCH) begin
            hi_valid_q <= 1'b1;
            hi_last_q <= cur_addr[15:8];
        end
    end

    // =============================================================
    // command strobes; early write or compressed timing opens write in command state
    wire act_cyc = state_q == dcrt_pkg::ST_CMD || state_q == dcrt_pkg::ST_WAIT;
    wire wr_on = state_q == dcrt_pkg::ST_WAIT ||
        (state_q == dcrt_pkg::ST_CMD && (early_wr || short_tm));
    assign mem_rd_cmd = act_cyc && (mm_act ? !mm_wr_q : xt == dcrt_pkg::TT_READ);
    assign io_wr_cmd = wr_on && !mm_act && xt == dcrt_pkg::TT_READ;
    assign io_rd_cmd = act_cyc && !mm_act && xt == dcrt_pkg::TT_WRITE;
    assign mem_wr_cmd = wr_on && (mm_act ? mm_wr_q : xt == dcrt_pkg::TT_WRITE);
    assign terminal_count = tc_end &&
        (short_tm ? state_q == dcrt_pkg::ST_CMD : fin);
    assign channel_acknowledge = ack_pol ? ack_hit : ~ack_hit;
    assign addr_strobe = state_q == dcrt_pkg::ST_LATCH;
    assign addr_out = cur_addr;
    assign io_rdata = rdata_q;
    assign mask_set = mask_set_q;

    // =============================================================
    // two-entry record buffer; when full, no new cycle starts
    wire push = fin && (!mm_act || mm_wr_q);
    wire pop = xfer_valid && xfer_ready;
    assign xfer_valid = fcnt_q != CW'(0);
    assign xfer_data = fifo_q[rp_q];

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wp_q <= '0;
            rp_q <= '0;
            fcnt_q <= '0;
            for (int i = 0; i < XDEPTH; i++)
                fifo_q[i] <= '0;
        end else begin
            if (push) begin
                fifo_q[wp_q] <= XW'({tc_end, act_chan, cur_addr});
                wp_q <= (wp_q == AW'(XDEPTH - 1)) ? '0 : wp_q + AW'(1);
            end
            if (pop)
                rp_q <= (rp_q == AW'(XDEPTH - 1)) ? '0 : rp_q + AW'(1);
            fcnt_q <= fcnt_q + CW'(push) - CW'(pop);
        end
    end

    // =============================================================
    // checks
    default clocking dcrt_cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    normal_len_a: assert property ((state_q == dcrt_pkg::ST_CMD && !short_tm) |=>
        state_q == dcrt_pkg::ST_WAIT ##1 state_q == dcrt_pkg::ST_WAIT)
        else $error("normal timing lost a wait state");
    short_len_a: assert property ((state_q == dcrt_pkg::ST_CMD && short_tm) ##1
        (io_ready || no_cmd) |=> state_q == dcrt_pkg::ST_FIN)
        else $error("compressed cycle did not finish after one wait");
    both_cmds_a: assert property ((state_q == dcrt_pkg::ST_CMD && short_tm &&
        !mm_act && xt == dcrt_pkg::TT_READ) |-> (mem_rd_cmd && io_wr_cmd))
        else $error("compressed read missing a command");
    tc_short_a: assert property ((state_q == dcrt_pkg::ST_CMD && short_tm && tc_end) |->
        terminal_count ##1 !terminal_count)
        else $error("terminal count not in command state");
    auto_reload_a: assert property ((fin && tc_end && mode_q[act_chan][`DCRT_MODE_AI] &&
        !io_wr) |=> cnt_q[$past(act_chan)] == base_cnt_q[$past(act_chan)] &&
        addr_q[$past(act_chan)] == base_addr_q[$past(act_chan)])
        else $error("autoinit did not reload");
    halt_a: assert property ((fin && tc_end && !mode_q[act_chan][`DCRT_MODE_AI]) |=>
        halted_q[$past(act_chan)] && mask_set_q[$past(act_chan)] &&
        state_q == dcrt_pkg::ST_IDLE)
        else $error("channel not halted at rollover");
    disable_a: assert property ((state_q == dcrt_pkg::ST_IDLE && sub_off) |=>
        state_q == dcrt_pkg::ST_IDLE)
        else $error("cycle started while disabled");
    verify_quiet_a: assert property ((state_q != dcrt_pkg::ST_IDLE && no_cmd) |->
        !(mem_rd_cmd || mem_wr_cmd || io_rd_cmd || io_wr_cmd))
        else $error("strobe during verify or illegal cycle");
    mode_read_a: assert property (rd_mode |=>
        io_rdata[1:0] == `DCRT_MODE_RD_LOW && mrd_q == $past(mrd_q) + 2'h1)
        else $error("mode read sequence wrong");
    cmd_clear_a: assert property (mclr |=> cmd_q == `DCRT_CMD_RST)
        else $error("master clear left control set");

    normal_xfer_c: cover property (state_q == dcrt_pkg::ST_CMD && !short_tm ##3 fin);
    short_xfer_c: cover property (state_q == dcrt_pkg::ST_CMD && short_tm ##2 fin);
    reload_c: cover property (fin && tc_end && mode_q[act_chan][`DCRT_MODE_AI]);
    mm_phase_c: cover property (fin && mm_act && mm_wr_q);
    stall_c: cover property (state_q == dcrt_pkg::ST_IDLE && found && !room);
endmodule // dcrt_core

// ---- dcrt_periph.sv ----
// dcrt_periph.sv: peripheral, ready source and record receiver on the far side
`timescale 1ns/100ps
module dcrt_periph (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [3:0] want,
    input wire logic req_low,
    input wire logic slow,
    output logic [3:0] channel_request,
    output logic io_ready,
    input wire logic xfer_valid,
    input wire logic [18:0] xfer_data,
    output logic xfer_ready,
    output logic [7:0] pops,
    output logic [18:0] last_rec
);
    logic tog_q;
    // =============================================================
    // request level follows the configured polarity
    assign channel_request = want ^ {4{req_low}};
    // slow mode stalls ready and the receiver on alternate cycles
    assign io_ready = ~slow | tog_q;
    assign xfer_ready = ~slow | ~tog_q;
    // =============================================================
    // take records; keep the last one for the bench
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tog_q <= 1'b0;
            pops <= 8'h00;
            last_rec <= 19'h00000;
        end else begin
            tog_q <= ~tog_q;
            if (xfer_valid && xfer_ready) begin
                pops <= pops + 8'h01;
                last_rec <= xfer_data;
            end
        end
    end
endmodule // dcrt_periph

// ---- dcrt_core_bench.sv ----
// dcrt_core_bench.sv: self-checking bench for the channel block
`timescale 1ns/100ps
module dcrt_core_bench;
    logic clk_sys = 1'b0, resetn = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
    logic req_low = 1'b0, slow = 1'b0, ack_on = 1'b0;
    logic [3:0] io_addr = 4'h0, want = 4'h0, channel_request, channel_acknowledge, mask_set;
    logic [7:0] io_wdata = 8'h00, io_rdata, rb, pops;
    logic io_ready, addr_strobe, terminal_count, mem_rd_cmd, mem_wr_cmd, io_rd_cmd, io_wr_cmd;
    logic xfer_valid, xfer_ready;
    logic [15:0] addr_out, w;
    logic [18:0] xfer_data, last_rec;
    logic [7:0] mt [4] = '{8'h10, 8'h65, 8'h8a, 8'hcf};
    int n_fail = 0, checks = 0, cyc = 0, rd_n = 0, wr_n = 0, stb_n = 0, tcc_n = 0, msk_n = 0;
    int b0;
    always #5 clk_sys = ~clk_sys;
    dcrt_core dut (.clk_sys(clk_sys), .resetn(resetn), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .channel_request(channel_request), .channel_acknowledge(channel_acknowledge),
        .io_ready(io_ready), .addr_out(addr_out), .addr_strobe(addr_strobe),
        .terminal_count(terminal_count), .mem_rd_cmd(mem_rd_cmd), .mem_wr_cmd(mem_wr_cmd),
        .io_rd_cmd(io_rd_cmd), .io_wr_cmd(io_wr_cmd), .mask_set(mask_set),
        .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_data(xfer_data));
    dcrt_periph far (.clk_sys(clk_sys), .resetn(resetn), .want(want), .req_low(req_low),
        .slow(slow), .channel_request(channel_request), .io_ready(io_ready),
        .xfer_valid(xfer_valid), .xfer_data(xfer_data), .xfer_ready(xfer_ready),
        .pops(pops), .last_rec(last_rec));
    // =============================================================
    // strobe activity counters; tc with a strobe means command-state tc
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        rd_n <= rd_n + int'(mem_rd_cmd);
        wr_n <= wr_n + int'(mem_wr_cmd);
        stb_n <= stb_n + int'(mem_rd_cmd | mem_wr_cmd | io_rd_cmd | io_wr_cmd);
        tcc_n <= tcc_n + int'(terminal_count & (mem_rd_cmd | mem_wr_cmd));
        msk_n <= msk_n + $countones(mask_set);
    end
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge clk_sys) begin
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    // =============================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // strobe is lowered a cycle before the next access may raise it
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk_sys);
        #1 io_wr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        io_addr = a;
        io_rd = 1'b1;
        @(posedge clk_sys);
        #1 io_rd = 1'b0;
        rb = io_rdata;
        @(posedge clk_sys);
        #1;
    endtask
    // words go low byte first after clearing the byte pointer
    task automatic wrw(input logic [3:0] a, input logic [15:0] v);
        wr(4'hc, 8'h00);
        wr(a, v[7:0]);
        wr(a, v[15:8]);
    endtask
    task automatic rdw(input logic [3:0] a);
        wr(4'hc, 8'h00);
        rd(a);
        w[7:0] = rb;
        rd(a);
        w[15:8] = rb;
    endtask
    // request until acknowledged, then wait for n records
    task automatic xfer(input int ch, input int n);
        int p0;
        p0 = pops;
        want[ch] = 1'b1;
        for (int i = 0; i < 50 && channel_acknowledge[ch] !== ack_on; i++) @(posedge clk_sys);
        #1 want[ch] = 1'b0;
        for (int i = 0; i < 200 && pops != p0 + n; i++) @(posedge clk_sys);
        #1 chk(pops, p0 + n);
    endtask
    // a request that must never be acknowledged
    task automatic quiet(input int ch);
        logic seen;
        seen = 1'b0;
        want[ch] = 1'b1;
        repeat (30) begin
            @(posedge clk_sys);
            if (channel_acknowledge[ch] === ack_on) seen = 1'b1;
        end
        #1 want[ch] = 1'b0;
        chk(seen, 1'b0);
    endtask
    // =============================================================
    task automatic t_regs();
        rd(4'h8);
        chk(rb, 8'h00);
        wr(4'h8, 8'h5a);
        rd(4'h8);
        chk(rb, 8'h5a);
        wr(4'hd, 8'h00);
        rd(4'h8);
        chk(rb, 8'h00);
        rd(4'h9);
        chk(rb, 8'h00);
        for (int i = 0; i < 4; i++) wr(4'hb, mt[i]);
        wr(4'he, 8'h00);
        for (int i = 0; i < 5; i++) begin
            rd(4'hb);
            chk(rb, mt[i % 4] | 8'h03);
        end
        wr(4'he, 8'h00);
        rd(4'hb);
        chk(rb, 8'h13);
        $display("regs test done");
    endtask
    task automatic t_normal();
        wrw(4'h0, 16'h1234);
        wrw(4'h1, 16'h0001);
        wr(4'hb, 8'h58);
        b0 = rd_n;
        xfer(0, 1);
        chk(rd_n - b0, 3);
        chk(last_rec, {1'b0, 2'h0, 16'h1234});
        b0 = msk_n;
        xfer(0, 1);
        chk(last_rec, {1'b1, 2'h0, 16'h1235});
        chk(msk_n - b0, 0);
        rdw(4'h0);
        chk(w, 16'h1234);
        rdw(4'h1);
        chk(w, 16'h0001);
        $display("normal test done");
    endtask
    task automatic t_short();
        int t0, m0;
        // polarity flips only while disabled, else every idle request looks active
        wr(4'h8, 8'hcc);
        ack_on = 1'b1;
        req_low = 1'b1;
        wr(4'h8, 8'hc8); // compressed with memory pairing off
        chk(channel_acknowledge, 4'h0);
        wrw(4'h2, 16'h0100);
        wrw(4'h3, 16'h0000);
        wr(4'hb, 8'h65);
        b0 = wr_n;
        t0 = tcc_n;
        m0 = msk_n;
        xfer(1, 1);
        chk(wr_n - b0, 2);
        chk(tcc_n - t0, 1);
        chk(msk_n - m0, 1);
        rdw(4'h2);
        chk(w, 16'h00ff);
        rdw(4'h3);
        chk(w, 16'hffff);
        quiet(1);
        $display("compressed test done");
    endtask
    task automatic t_verify();
        wr(4'h8, 8'h04);
        ack_on = 1'b0;
        req_low = 1'b0;
        slow = 1'b1;
        wrw(4'h4, 16'h0000);
        wrw(4'h5, 16'h0001);
        wr(4'hb, 8'h82);
        wr(4'h8, 8'h00);
        b0 = stb_n;
        xfer(2, 2);
        chk(stb_n - b0, 0);
        chk(last_rec, {1'b1, 2'h2, 16'h0001});
        slow = 1'b0;
        wr(4'h8, 8'h04);
        wrw(4'h6, 16'h0000);
        wrw(4'h7, 16'h0000);
        wr(4'hb, 8'h47);
        quiet(3);
        wr(4'h8, 8'h20); // normal timing with the early write
        b0 = wr_n;
        xfer(3, 1);
        chk(wr_n - b0, 3);
        $display("verify and disable test done");
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk_sys);
        #1 resetn = 1'b1;
        t_regs();
        t_normal();
        t_short();
        t_verify();
        end_of_test();
    end
endmodule // dcrt_core_bench
